// ==== rtl/asl_pkg.sv ====
package asl_pkg;
  localparam logic [7:0] ADDR_SLOT_CTL = 8'h05;
  localparam logic [7:0] ADDR_BATTERY = 8'h06;
  localparam logic [7:0] ADDR_LIM_RATE = 8'h07;
  localparam logic [7:0] ADDR_LIM_THR = 8'h08;
  localparam logic [7:0] ADDR_INFLECT = 8'h09;
  localparam logic [7:0] ADDR_STATUS = 8'h0A;

  localparam logic [7:0] RST_SLOT_CTL = 8'h00;
  localparam logic [7:0] RST_BATTERY = 8'h00;
  localparam logic [7:0] RST_LIM_RATE = 8'hA4;
  localparam logic [7:0] RST_LIM_THR = 8'h51;
  localparam logic [7:0] RST_INFLECT = 8'h22;

  localparam int WIDTH_BIT = 7;
  localparam int AUTO_SLOT_BIT = 4;
  localparam int TRACK_BIT = 2;
  localparam int GRED_BIT = 5;
  localparam int WARN_BIT = 0;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_MUTE = 2'h2;
  localparam logic [1:0] MODE_COND = 2'h3;

  localparam logic [4:0] WORD_BITS_24 = 5'h18;
  localparam logic [4:0] WORD_BITS_16 = 5'h10;
  localparam logic [4:0] THR_MAX = 5'h1F;
  localparam logic [10:0] CNT_MAX = 11'h7FF;

  typedef struct packed {
    logic [7:0] slot_ctl;
    logic [7:0] lim_rate;
    logic [7:0] lim_thr;
    logic [7:0] inflect;
    logic [7:0] bat;
    logic [7:0] rdata;
    logic mute;
    logic lim_on;
    logic gred;
    logic warn;
    logic [4:0] thr;
  } asl_regs_s;

  typedef struct packed {
    logic [10:0] cnt;
    logic fs_d;
    logic [23:0] sh;
    logic [23:0] word;
    logic valid;
  } asl_cap_s;

  // bit clocks per chip slot
  function automatic logic [6:0] asl_bclks(input logic [2:0] code);
    case (code)
      3'h0: asl_bclks = 7'h10;
      3'h1: asl_bclks = 7'h18;
      3'h2: asl_bclks = 7'h20;
      3'h3: asl_bclks = 7'h30;
      default: asl_bclks = 7'h40;
    endcase
  endfunction

  // threshold code raised by battery drop times (slope + 1), saturated at THR_MAX
  function automatic logic [4:0] asl_track_thr(input logic [4:0] thr,
    input logic [7:0] drop, input logic [1:0] slope);
    logic [10:0] sum;
    sum = 11'(thr) + 11'(drop) * 11'({1'b0, slope} + 3'h1);
    asl_track_thr = (sum > 11'(THR_MAX)) ? THR_MAX : sum[4:0];
  endfunction
endpackage

// ==== rtl/asl_slot_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface asl_slot_if;
  logic [3:0] slot_idx;
  logic [6:0] bclks;
  logic w16;
  logic [23:0] word;
  logic valid;
  modport cfg (output slot_idx, bclks, w16, input word, valid);
  modport cap (input slot_idx, bclks, w16, output word, valid);
endinterface
`default_nettype wire

// ==== rtl/asl_slot_capture.sv ====
`timescale 1ns/10ps
`default_nettype none
module asl_slot_capture (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic bclk_tick_in,
  input wire logic fsync_in,
  input wire logic serial_audio_in,
  asl_slot_if.cap slot
);
  asl_pkg::asl_cap_s st;
  asl_pkg::asl_cap_s next_st;
  logic [10:0] start;
  logic [10:0] stop;

  // slot offset and word end from the frame boundary
  assign start = 11'(slot.slot_idx) * 11'(slot.bclks);
  assign stop = start + 11'(slot.w16 ? asl_pkg::WORD_BITS_16
                                     : asl_pkg::WORD_BITS_24);

  always_comb
  begin
    logic [10:0] cnt;
    cnt = st.cnt;
    next_st = st;
    next_st.valid = 1'b0;
    if (bclk_tick_in)
    begin
      next_st.fs_d = fsync_in;
      if (fsync_in && !st.fs_d)
        cnt = 11'h000;
      else if (st.cnt != asl_pkg::CNT_MAX)
        cnt = st.cnt + 11'h001;
      next_st.cnt = cnt;
      if (cnt >= start && cnt < stop)
      begin
        next_st.sh = {st.sh[22:0], serial_audio_in};
        if (cnt == stop - 11'h001)
        begin
          next_st.valid = 1'b1;
          next_st.word = slot.w16 ? {st.sh[14:0], serial_audio_in, 8'h00}
                                  : {st.sh[22:0], serial_audio_in};
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign slot.word = st.word;
  assign slot.valid = st.valid;

  chk_word_end_offset: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) st.valid |-> st.cnt == stop - 11'h001)
    else $error("word ended away from slot end");
  chk_short_word_pad: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) st.valid && slot.w16 |-> st.word[7:0] == 8'h00)
    else $error("16-bit word not left aligned");
  chk_valid_single: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) st.valid |=> !st.valid)
    else $error("word strobe longer than one cycle");
endmodule
`default_nettype wire

// ==== rtl/asl_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Function
// - width bit set means 16-bit words, else 24
// - auto slot bit takes slot from address pins
// - battery register shows eight-bit reading, read-only
// - rate register resets A4, release/attack rate codes
// - tracking bit lets threshold follow battery voltage
// - mode 00 all off, 01 limiter on
// - mode 10 mutes while battery below inflection
// - mode 11 limiter engages only below inflection
// - threshold register resets 51, five-bit threshold code
// - slope code sets threshold-to-battery drop ratio
// - inflection compared with reading in same scale
// - status flag shows gain currently being reduced
// - slot spans programmed bit clocks, 000 is 16
module asl_top (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] battery_level_in,
  input wire logic gain_reducing_in,
  input wire logic [1:0] addr_pin_in,
  input wire logic [2:0] bit_clocks_per_chip_in,
  input wire logic bclk_tick_in,
  input wire logic fsync_in,
  input wire logic serial_audio_in,
  output logic [7:0] reg_rdata_out,
  output logic mute_out,
  output logic limiter_active_out,
  output logic gain_reduced_flag_out,
  output logic battery_warning_out,
  output logic [4:0] attack_threshold_out,
  output logic [1:0] release_rate_sel_out,
  output logic [1:0] attack_rate_sel_out,
  output logic threshold_tracking_out,
  output logic [23:0] audio_word_out,
  output logic audio_valid_out
);
  asl_pkg::asl_regs_s st;
  asl_pkg::asl_regs_s next_st;
  asl_slot_if slot ();
  logic [1:0] limiter_mode_sel;
  logic below;

  assign limiter_mode_sel = st.lim_rate[1:0];
  // same code scale on both sides
  assign below = st.bat < st.inflect;

  // code n is slot n+1, index n from the frame start
  assign slot.slot_idx = st.slot_ctl[asl_pkg::AUTO_SLOT_BIT]
                         ? {2'b00, addr_pin_in} : st.slot_ctl[3:0];
  assign slot.bclks = asl_pkg::asl_bclks(bit_clocks_per_chip_in);
  assign slot.w16 = st.slot_ctl[asl_pkg::WIDTH_BIT];

  asl_slot_capture u_capture (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .bclk_tick_in(bclk_tick_in),
    .fsync_in(fsync_in),
    .serial_audio_in(serial_audio_in),
    .slot(slot.cap)
  );

  always_comb
  begin
    next_st = st;
    next_st.bat = battery_level_in;
    if (reg_wr_in)
    begin
      if (reg_addr_in == asl_pkg::ADDR_SLOT_CTL)
        next_st.slot_ctl = reg_wdata_in;
      else if (reg_addr_in == asl_pkg::ADDR_LIM_RATE)
        next_st.lim_rate = reg_wdata_in;
      else if (reg_addr_in == asl_pkg::ADDR_LIM_THR)
        next_st.lim_thr = reg_wdata_in;
      else if (reg_addr_in == asl_pkg::ADDR_INFLECT)
        next_st.inflect = reg_wdata_in;
    end
    if (reg_rd_in)
    begin
      if (reg_addr_in == asl_pkg::ADDR_SLOT_CTL)
        next_st.rdata = st.slot_ctl;
      else if (reg_addr_in == asl_pkg::ADDR_BATTERY)
        next_st.rdata = st.bat;
      else if (reg_addr_in == asl_pkg::ADDR_LIM_RATE)
        next_st.rdata = st.lim_rate;
      else if (reg_addr_in == asl_pkg::ADDR_LIM_THR)
        next_st.rdata = st.lim_thr;
      else if (reg_addr_in == asl_pkg::ADDR_INFLECT)
        next_st.rdata = st.inflect;
      else if (reg_addr_in == asl_pkg::ADDR_STATUS)
      begin
        next_st.rdata = 8'h00;
        next_st.rdata[asl_pkg::GRED_BIT] = st.gred;
        next_st.rdata[asl_pkg::WARN_BIT] = st.warn;
      end
      else
        next_st.rdata = 8'h00;
    end
    next_st.mute = limiter_mode_sel == asl_pkg::MODE_MUTE && below;
    next_st.lim_on = limiter_mode_sel == asl_pkg::MODE_ON
                     || (limiter_mode_sel == asl_pkg::MODE_COND && below);
    next_st.gred = gain_reducing_in || st.mute;
    next_st.warn = st.bat <= st.inflect;
    if (st.lim_rate[asl_pkg::TRACK_BIT] && below)
      next_st.thr = asl_pkg::asl_track_thr(st.lim_thr[7:3],
                      st.inflect - st.bat, st.lim_thr[1:0]);
    else
      next_st.thr = st.lim_thr[7:3];
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st <= '0;
      st.slot_ctl <= asl_pkg::RST_SLOT_CTL;
      st.bat <= asl_pkg::RST_BATTERY;
      st.lim_rate <= asl_pkg::RST_LIM_RATE;
      st.lim_thr <= asl_pkg::RST_LIM_THR;
      st.inflect <= asl_pkg::RST_INFLECT;
      st.thr <= asl_pkg::RST_LIM_THR[7:3];
    end
    else
      st <= next_st;
  end

  assign reg_rdata_out = st.rdata;
  assign mute_out = st.mute;
  assign limiter_active_out = st.lim_on;
  assign gain_reduced_flag_out = st.gred;
  assign battery_warning_out = st.warn;
  assign attack_threshold_out = st.thr;
  // rate codes drive the limiter timing
  assign release_rate_sel_out = st.lim_rate[7:6];
  assign attack_rate_sel_out = st.lim_rate[5:4];
  assign threshold_tracking_out = st.lim_rate[asl_pkg::TRACK_BIT];
  assign audio_word_out = slot.word;
  assign audio_valid_out = slot.valid;

  chk_mute_below: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    mute_out == $past(limiter_mode_sel == asl_pkg::MODE_MUTE && below))
    else $error("mute does not follow mode and battery");
  chk_limiter_engage: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    $past(limiter_mode_sel == asl_pkg::MODE_COND) |->
    limiter_active_out == $past(below))
    else $error("conditional limiter wrong");
  chk_mode_off: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    $past(limiter_mode_sel == asl_pkg::MODE_OFF) |->
    !limiter_active_out && !mute_out)
    else $error("limiter or mute active in off mode");
  chk_battery_read: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    reg_rd_in && reg_addr_in == asl_pkg::ADDR_BATTERY
    && !$past(sys_rst_in) |=> reg_rdata_out == $past(battery_level_in, 2))
    else $error("battery read-back wrong");
  chk_flag_sets: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    $past(gain_reducing_in) |-> gain_reduced_flag_out)
    else $error("gain reduced flag missing");
  chk_fixed_thr: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    $past(!st.lim_rate[asl_pkg::TRACK_BIT]) |->
    attack_threshold_out == $past(st.lim_thr[7:3]))
    else $error("fixed threshold moved");
  chk_slope_drop: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    $past(st.lim_rate[asl_pkg::TRACK_BIT]
    && {1'b0, st.bat} + 9'h001 == {1'b0, st.inflect}
    && st.lim_thr[7:3] < 5'h10) |->
    attack_threshold_out == $past(st.lim_thr[7:3]) + 5'h01
    + 5'($past(st.lim_thr[1:0])))
    else $error("threshold slope wrong");
  chk_rate_write: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == asl_pkg::ADDR_LIM_RATE |=>
    release_rate_sel_out == $past(reg_wdata_in[7:6])
    && attack_rate_sel_out == $past(reg_wdata_in[5:4]))
    else $error("rate codes not written");
  chk_slot_len: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    bit_clocks_per_chip_in == 3'h0 |-> slot.bclks == 7'h10)
    else $error("code 000 not sixteen bit clocks");
  chk_auto_slot: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    st.slot_ctl[asl_pkg::AUTO_SLOT_BIT] |-> slot.slot_idx[3:2] == 2'b00)
    else $error("auto slot beyond pin range");
  chk_warn_level: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    !$past(sys_rst_in) |->
    battery_warning_out == $past(st.bat <= st.inflect))
    else $error("battery warning level wrong");
  chk_status_read: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    reg_rd_in && reg_addr_in == asl_pkg::ADDR_STATUS |=>
    reg_rdata_out[asl_pkg::GRED_BIT] == $past(gain_reduced_flag_out))
    else $error("status flag read-back wrong");
  chk_mute_flag: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    mute_out |=> gain_reduced_flag_out)
    else $error("mute without gain reduced flag");
endmodule
`default_nettype wire

// ==== dv/asl_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module asl_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // one-cycle write strobe, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask

  // one-cycle read strobe, data taken once registered
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rst, wr, rd, gred, tick, fs, sd, mute, act, flag, warn;
  logic trk, vld;
  logic [7:0] addr, wdata, rdata, bat, rv;
  logic [1:0] pins, rrs, ars;
  logic [2:0] bcode;
  logic [4:0] thr;
  logic [23:0] word;
  int errors, n_compared, cyc;

  asl_host_model host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  asl_top dut (.sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .battery_level_in(bat), .gain_reducing_in(gred),
    .addr_pin_in(pins), .bit_clocks_per_chip_in(bcode),
    .bclk_tick_in(tick), .fsync_in(fs), .serial_audio_in(sd),
    .reg_rdata_out(rdata), .mute_out(mute), .limiter_active_out(act),
    .gain_reduced_flag_out(flag), .battery_warning_out(warn),
    .attack_threshold_out(thr), .release_rate_sel_out(rrs),
    .attack_rate_sel_out(ars), .threshold_tracking_out(trk),
    .audio_word_out(word), .audio_valid_out(vld));

  task automatic end_sim();
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_regs();
    host.rd(8'h05, rv);
    chk(rv, 8'h00);
    host.rd(8'h07, rv);
    chk(rv, 8'hA4);
    host.rd(8'h08, rv);
    chk(rv, 8'h51);
    host.rd(8'h09, rv);
    chk(rv, 8'h22);
    chk({rrs, ars, trk, thr}, {2'h2, 2'h2, 1'b1, 5'h0A});
    for (int k = 0; k < 4; k++)
    begin
      host.wr(8'h07, {2'(k), 2'(3 - k), 4'h0});
      chk({rrs, ars, trk}, {2'(k), 2'(3 - k), 1'b0});
    end
    host.rd(8'h07, rv);
    chk(rv, 8'hC0);
    bat = 8'h5A;
    host.wr(8'h06, 8'hFF);
    host.rd(8'h06, rv);
    chk(rv, 8'h5A);
    host.wr(8'h0C, 8'h77);
    host.rd(8'h0C, rv);
    chk(rv, 8'h00);
  endtask

  task automatic t_mode();
    logic [7:0] b[3];
    logic lo;
    b = '{8'h10, 8'h22, 8'h30};
    for (int i = 0; i < 3; i++)
      for (int m = 0; m < 4; m++)
      begin
        bat = b[i];
        host.wr(8'h07, 8'hA0 | 8'(m));
        settle();
        lo = (b[i] < 8'h22);
        chk({mute, act, warn, flag}, {m == 2 && lo, m == 1 || (m == 3 && lo),
          b[i] <= 8'h22, m == 2 && lo});
      end
    host.wr(8'h07, 8'hA0);
    gred = 1'b1;
    settle();
    chk(flag, 1'b1);
    host.rd(8'h0A, rv);
    chk(rv, 8'h20);
    gred = 1'b0;
    settle();
    chk(flag, 1'b0);
    bat = 8'h22;
    settle();
    host.rd(8'h0A, rv);
    chk(rv, 8'h01);
  endtask

  task automatic t_track();
    bat = 8'h20;
    host.wr(8'h07, 8'hA4);
    for (int s = 0; s < 4; s++)
    begin
      host.wr(8'h08, {5'h02, 1'b0, 2'(s)});
      settle();
      chk(thr, 5'(2 + 2 * (s + 1)));
    end
    bat = 8'h21;
    settle();
    chk(thr, 5'h06);
    bat = 8'h00;
    settle();
    chk(thr, 5'h1F);
    host.wr(8'h07, 8'hA0);
    settle();
    chk(thr, 5'h02);
  endtask

  task automatic frame(input int off, input int w, input logic [23:0] wd,
    input logic [23:0] exp);
    logic [23:0] got;
    int seen;
    got = 24'h0;
    seen = 0;
    for (int i = 0; i < off + w + 4; i++)
    begin
      @(posedge clk);
      #1;
      if (vld === 1'b1)
      begin
        got = word;
        seen++;
      end
      tick = 1'b1;
      fs = (i == 0);
      sd = (i >= off && i < off + w) ? wd[w - 1 - (i - off)] : ~sd;
    end
    @(posedge clk);
    #1;
    tick = 1'b0;
    chk(24'(seen), 24'h1);
    chk(got, exp);
  endtask

  task automatic t_audio();
    int per[5];
    per = '{16, 24, 32, 48, 64};
    host.wr(8'h05, 8'h81);
    for (int k = 0; k < 5; k++)
    begin
      bcode = 3'(k);
      frame(per[k], 16, 24'h00A5C3, 24'hA5C300);
    end
    host.wr(8'h05, 8'h10);
    pins = 2'h2;
    bcode = 3'h2;
    frame(64, 24, 24'h3C5A96, 24'h3C5A96);
    host.wr(8'h05, 8'h8F);
    bcode = 3'h0;
    frame(240, 16, 24'h00E718, 24'hE71800);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  initial
  begin
    rst = 1'b1;
    bat = 8'h30;
    gred = 1'b0;
    pins = 2'h0;
    bcode = 3'h0;
    tick = 1'b0;
    fs = 1'b0;
    sd = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    t_regs();
    t_mode();
    t_track();
    t_audio();
    end_sim();
  end
endmodule
`default_nettype wire
